// file: ctb_pkg.sv
// Package for the core time base and timers block
package ctb_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] CTB_OFF_TBL     = 8'h00;
  localparam logic [7:0] CTB_OFF_TBU     = 8'h04;
  localparam logic [7:0] CTB_OFF_PIT     = 8'h08;
  localparam logic [7:0] CTB_OFF_CTRL    = 8'h0C;
  localparam logic [7:0] CTB_OFF_STATUS  = 8'h10;
  localparam logic [7:0] CTB_OFF_CLEAR   = 8'h14;
  localparam logic [7:0] CTB_OFF_ENABLE  = 8'h18;

  // ==========================================================
  // Control register field positions
  localparam int CTB_CTRL_EXT_CLK  = 0;
  localparam int CTB_CTRL_RELOAD   = 1;
  localparam int CTB_CTRL_FIT_SEL  = 2;
  localparam int CTB_CTRL_WD_SEL   = 4;
  localparam int CTB_CTRL_WD_RST   = 6;
  localparam int CTB_CTRL_WD_EN    = 8;

  // Status bit positions
  localparam int CTB_ST_PIT  = 0;
  localparam int CTB_ST_FIT  = 1;
  localparam int CTB_ST_WD   = 2;
  localparam int CTB_ST_NUM  = 3;

  // Reset values
  localparam logic [31:0] CTB_CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0]  CTB_ENA_RESET  = 3'h0;

  // Time base bits tapped by the two selectable timers
  localparam int CTB_FIT_TAP0 = 9;
  localparam int CTB_FIT_TAP1 = 13;
  localparam int CTB_FIT_TAP2 = 17;
  localparam int CTB_FIT_TAP3 = 21;
  localparam int CTB_WD_TAP0  = 17;
  localparam int CTB_WD_TAP1  = 21;
  localparam int CTB_WD_TAP2  = 25;
  localparam int CTB_WD_TAP3  = 29;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    CTB_RST_NONE   = 2'b00,
    CTB_RST_CORE   = 2'b01,
    CTB_RST_CHIP   = 2'b10,
    CTB_RST_SYSTEM = 2'b11
  } ctb_rst_kind_t;

  typedef enum logic [1:0] {
    CTB_WD_IDLE   = 2'b00,
    CTB_WD_ONCE   = 2'b01,
    CTB_WD_TWICE  = 2'b10
  } ctb_wd_state_t;

  typedef struct packed {
    logic          wd_en;
    ctb_rst_kind_t wd_rst;
    logic [1:0]    wd_sel;
    logic [1:0]    fit_sel;
    logic          reload;
    logic          ext_clk;
  } ctb_ctrl_t;

endpackage : ctb_pkg

// file: ctb_timers.sv
// Core time base with interval, fixed interval and watchdog timers
// How it works
// - 64-bit time base ticks from CPU clock or external timer clock
// - Time base wraps silently on overflow, no flag or interrupt
// - All timers update on time base ticks; a time base write can also fire fixed interval or watchdog events
// - Interval count is 32 bits, loaded by software, minus one per tick
// - At zero the interval count stops and raises its interrupt
// - With auto-reload, zero reloads the last written value and continues
// - Fixed interval interrupt on 0-to-1 of one of four time base bits
// - Watchdog raises periodic critical interrupt at each interval end
// - Software picks watchdog period from four and the reset kind
// - Two intervals without status clear issue the selected reset
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ctb_timers
  import ctb_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        TIMER_CLK_TICK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  output logic             PIT_IRQ,
  output logic             FIT_IRQ,
  output logic             WD_IRQ,
  output logic             WD_RESET,
  output logic      [1:0]  WD_RESET_KIND
);

  // ==========================================================
  // Tap decoding shared by fixed interval and watchdog selection
  function automatic logic tap4(input logic [63:0] v,
                                input logic [1:0]  s,
                                input logic        wd);
    int b;
    b = 0;
    unique case (s)
      2'd0: b = wd ? CTB_WD_TAP0 : CTB_FIT_TAP0;
      2'd1: b = wd ? CTB_WD_TAP1 : CTB_FIT_TAP1;
      2'd2: b = wd ? CTB_WD_TAP2 : CTB_FIT_TAP2;
      2'd3: b = wd ? CTB_WD_TAP3 : CTB_FIT_TAP3;
    endcase
    return v[b];
  endfunction : tap4

  // ==========================================================
  // Bus decode
  logic        wr_en;
  logic        rd_hit;
  logic [63:0] time_base;
  logic [31:0] interval_count;
  logic [31:0] reload_value;
  ctb_ctrl_t   ctrl;
  logic [2:0]  status;
  logic [2:0]  enable;
  logic        tick;
  logic        fit_prev;
  logic        wd_prev;
  logic        fit_bit;
  logic        wd_bit;
  logic        fit_event;
  logic        wd_event;
  logic        pit_event;
  logic        pit_load;
  logic [2:0]  events;
  logic [2:0]  clears;
  ctb_wd_state_t wd_state;

  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign PREADY  = 1'b1;
  assign rd_hit  = (PADDR == CTB_OFF_TBL) || (PADDR == CTB_OFF_TBU)
                || (PADDR == CTB_OFF_PIT) || (PADDR == CTB_OFF_CTRL)
                || (PADDR == CTB_OFF_STATUS) || (PADDR == CTB_OFF_CLEAR)
                || (PADDR == CTB_OFF_ENABLE);
  // Unmapped offsets answer with an error rather than silently
  assign PSLVERR = PSEL && PENABLE && !rd_hit;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        CTB_OFF_TBL:    PRDATA <= time_base[31:0];
        CTB_OFF_TBU:    PRDATA <= time_base[63:32];
        CTB_OFF_PIT:    PRDATA <= interval_count;
        CTB_OFF_CTRL:   PRDATA <= {23'h0, ctrl};
        CTB_OFF_STATUS: PRDATA <= {29'h0, status};
        CTB_OFF_ENABLE: PRDATA <= {29'h0, enable};
        default:        PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Control and enable registers
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl <= ctb_ctrl_t'(CTB_CTRL_RESET[8:0]);
    end else if (wr_en && PADDR == CTB_OFF_CTRL) begin
      ctrl <= ctb_ctrl_t'(PWDATA[8:0]);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      enable <= CTB_ENA_RESET;
    end else if (wr_en && PADDR == CTB_OFF_ENABLE) begin
      enable <= PWDATA[2:0];
    end
  end

  // ==========================================================
  // Time base
  // External tick is a synchronous enable, so no second domain
  assign tick = ctrl.ext_clk ? TIMER_CLK_TICK : 1'b1;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      time_base <= 64'h0000_0000_0000_0000;
    end else if (wr_en && PADDR == CTB_OFF_TBL) begin
      time_base[31:0] <= PWDATA;
    end else if (wr_en && PADDR == CTB_OFF_TBU) begin
      time_base[63:32] <= PWDATA;
    end else if (tick) begin
      time_base <= time_base + 64'h0000_0000_0000_0001;
    end
  end

  // ==========================================================
  // Programmable interval timer
  assign pit_load  = wr_en && PADDR == CTB_OFF_PIT;
  assign pit_event = tick && !pit_load && interval_count == 32'h0000_0001;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      reload_value <= 32'h0000_0000;
    end else if (pit_load) begin
      reload_value <= PWDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      interval_count <= 32'h0000_0000;
    end else if (pit_load) begin
      interval_count <= PWDATA;
    end else if (tick && interval_count != 32'h0000_0000) begin
      if (interval_count == 32'h0000_0001 && ctrl.reload) begin
        interval_count <= reload_value;
      end else begin
        interval_count <= interval_count - 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // Fixed interval and watchdog taps
  assign fit_bit   = tap4(time_base, ctrl.fit_sel, 1'b0);
  assign wd_bit    = tap4(time_base, ctrl.wd_sel, 1'b1);
  assign fit_event = fit_bit && !fit_prev;
  assign wd_event  = wd_bit && !wd_prev;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      fit_prev <= 1'b0;
      wd_prev  <= 1'b0;
    end else begin
      fit_prev <= fit_bit;
      wd_prev  <= wd_bit;
    end
  end

  // ==========================================================
  // Watchdog sequence
  // Stage leaves idle at the first interval end, then advances only while the status stays set
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      wd_state <= CTB_WD_IDLE;
    end else if (wd_event) begin
      unique case (wd_state)
        CTB_WD_IDLE: wd_state <= CTB_WD_ONCE;
        CTB_WD_ONCE: wd_state <= status[CTB_ST_WD] ? CTB_WD_TWICE
                                                   : CTB_WD_ONCE;
        CTB_WD_TWICE: wd_state <= CTB_WD_TWICE;
        default: wd_state <= CTB_WD_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      WD_RESET      <= 1'b0;
      WD_RESET_KIND <= 2'b00;
    end else if (ctrl.wd_en && wd_event && wd_state != CTB_WD_IDLE
                 && status[CTB_ST_WD] && !WD_RESET) begin
      WD_RESET      <= 1'b1;
      WD_RESET_KIND <= ctrl.wd_rst;
    end
  end

  // ==========================================================
  // Sticky status, clear and interrupt outputs
  assign events = {wd_event, fit_event, pit_event};
  assign clears = (wr_en && PADDR == CTB_OFF_CLEAR) ? PWDATA[2:0] : 3'h0;

  genvar gi;
  generate
    for (gi = 0; gi < CTB_ST_NUM; gi++) begin : g_status
      // A new event beats a clear in the same cycle
      always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
          status[gi] <= 1'b0;
        end else if (events[gi]) begin
          status[gi] <= 1'b1;
        end else if (clears[gi]) begin
          status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign PIT_IRQ = status[CTB_ST_PIT] && enable[CTB_ST_PIT];
  assign FIT_IRQ = status[CTB_ST_FIT] && enable[CTB_ST_FIT];
  assign WD_IRQ  = status[CTB_ST_WD] && enable[CTB_ST_WD];
  assign IRQ     = PIT_IRQ || FIT_IRQ || WD_IRQ;

endmodule : ctb_timers

`default_nettype wire

// file: ctb_timers_assertions.sv
// Assertion checker for the time base and timer block
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module ctb_timers_assertions
  import ctb_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       SYS_RST,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PWRITE,
  input wire logic       PREADY,
  input wire logic       PSLVERR,
  input wire logic       IRQ,
  input wire logic       PIT_IRQ,
  input wire logic       FIT_IRQ,
  input wire logic       WD_IRQ,
  input wire logic       WD_RESET,
  input wire logic [1:0] WD_RESET_KIND
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // Any write may touch clear or enable, so it frees the flags
  logic wr;
  assign wr = PSEL && PENABLE && PWRITE;
  a_irq_merge: assert property (
    IRQ == (PIT_IRQ | FIT_IRQ | WD_IRQ)) else $error("irq not merged");
  a_pit_hold: assert property (
    PIT_IRQ && !wr |=> PIT_IRQ) else $error("pit irq dropped");
  a_fit_hold: assert property (
    FIT_IRQ && !wr |=> FIT_IRQ) else $error("fit irq dropped");
  a_wd_hold: assert property (
    WD_IRQ && !wr |=> WD_IRQ) else $error("wd irq dropped");
  a_wd_rst_hold: assert property (
    WD_RESET |=> WD_RESET && $stable(WD_RESET_KIND))
    else $error("wd reset not held");
  a_kind_idle: assert property (
    !WD_RESET |-> WD_RESET_KIND == 2'b00) else $error("kind without reset");
  a_err_access: assert property (
    PSLVERR |-> PSEL && PENABLE) else $error("slverr outside access");
  a_ready_on: assert property (
    PREADY) else $error("pready low");
  c_pit: cover property ($rose(PIT_IRQ));
  c_fit: cover property ($rose(FIT_IRQ));
  c_wd_rst: cover property ($rose(WD_RESET));
endmodule : ctb_timers_assertions

bind ctb_timers ctb_timers_assertions i_chk (.*);
`default_nettype wire

// file: tb_ctb_timers.sv
// Self-checking bench for the time base and timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_ctb_timers import ctb_pkg::*;;
  logic        SYS_CLK, SYS_RST, TIMER_CLK_TICK, PSEL, PENABLE, PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, r, a, b, c, d;
  logic        PREADY, PSLVERR, IRQ, PIT_IRQ, FIT_IRQ, WD_IRQ, WD_RESET, e;
  logic [1:0]  WD_RESET_KIND;
  logic [2:0]  irqs;
  int          err_count = 0, checked = 0;
  typedef struct packed {logic [7:0] a; logic [31:0] w, x; logic er;} ctb_row_t;
  // Address, write value, read back, error
  ctb_row_t rows [5] = '{'{8'h18, 32'h5, 32'h5, 1'b0},
    '{8'h0C, 32'hBC, 32'hBC, 1'b0}, '{8'h14, 32'h7, 32'h0, 1'b0},
    '{8'h1C, 32'h1, 32'h0, 1'b1}, '{8'h04, 32'h12, 32'h12, 1'b0}};
  assign irqs = {WD_IRQ, FIT_IRQ, PIT_IRQ};
  ctb_timers i_dut (.*);
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // ==========================================================
  // Tasks
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // Settle one step so callers see outputs after the edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= dt;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    #1;
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    apb(1'b1, ad, dt);
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask : rd
  task automatic wirq(input int k);
    for (int i = 0; i < 300 && irqs[k] !== 1'b1; i++) @(posedge SYS_CLK);
    #1;
  endtask : wirq
  initial begin
    #200000;
    err_count++;
    close_out;
  end
  // ==========================================================
  // Tests
  initial begin
    {SYS_RST, TIMER_CLK_TICK, PSEL, PENABLE, PWRITE} = 5'h10;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    repeat (4) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    rd(CTB_OFF_CTRL);
    `CHK("ctrl rst", CTB_CTRL_RESET, r)
    rd(CTB_OFF_STATUS);
    `CHK("status rst", 32'h0, r)
    `CHK("irq rst", 1'b0, IRQ)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      `CHK("reg data", rows[i].x, r)
      `CHK("reg err", rows[i].er, e)
    end
    $display("test regs done");
    wr(CTB_OFF_CTRL, 32'h1);
    wr(CTB_OFF_PIT, 32'hFFFF);
    for (int t = 0; t < 2; t++) begin
      TIMER_CLK_TICK <= t[0];
      rd(CTB_OFF_TBL); a = r; rd(CTB_OFF_PIT); b = r;
      rd(CTB_OFF_TBL); c = r; rd(CTB_OFF_PIT); d = r;
      `CHK("tb step", c - a, b - d)
      `CHK("tb run", t[0], c != a)
    end
    $display("test tick done");
    wr(CTB_OFF_CTRL, 32'h0);
    wr(CTB_OFF_ENABLE, 32'h7);
    wr(CTB_OFF_CLEAR, 32'h7);
    wr(CTB_OFF_PIT, 32'd20);
    wirq(0);
    `CHK("pit irq", 1'b1, PIT_IRQ)
    rd(CTB_OFF_PIT);
    `CHK("pit stop", 32'h0, r)
    `CHK("pit sticky", 1'b1, PIT_IRQ)
    wr(CTB_OFF_ENABLE, 32'h6);
    `CHK("pit mask", 1'b0, PIT_IRQ)
    wr(CTB_OFF_CLEAR, 32'h1);
    rd(CTB_OFF_STATUS);
    `CHK("pit clear", 1'b0, r[CTB_ST_PIT])
    wr(CTB_OFF_ENABLE, 32'h1);
    wr(CTB_OFF_CTRL, 32'h2);
    wr(CTB_OFF_PIT, 32'd30);
    wirq(0);
    wr(CTB_OFF_CLEAR, 32'h1);
    rd(CTB_OFF_PIT);
    `CHK("pit reload", 1'b1, r > 32'd0 && r < 32'd31)
    wirq(0);
    `CHK("pit again", 1'b1, PIT_IRQ)
    $display("test interval done");
    wr(CTB_OFF_ENABLE, 32'h2);
    for (int s = 0; s < 4; s++) begin
      wr(CTB_OFF_CTRL, 32'(s << 2));
      wr(CTB_OFF_TBL, (32'h1 << (CTB_FIT_TAP0 + 4 * s)) - 32'd40);
      wr(CTB_OFF_CLEAR, 32'h2);
      `CHK("fit quiet", 1'b0, FIT_IRQ)
      wirq(1);
      `CHK("fit rise", 1'b1, FIT_IRQ)
    end
    $display("test fixed done");
    wr(CTB_OFF_ENABLE, 32'h7);
    wr(CTB_OFF_TBU, 32'hFFFF_FFFF);
    wr(CTB_OFF_TBL, 32'hFFFF_FFF0);
    wr(CTB_OFF_CLEAR, 32'h7);
    repeat (30) @(posedge SYS_CLK);
    rd(CTB_OFF_TBU);
    `CHK("tb wrap", 32'h0, r)
    `CHK("wrap quiet", 1'b0, IRQ)
    $display("test wrap done");
    // Clears after the first two ends only
    wr(CTB_OFF_CTRL, 32'h140);
    for (int n = 0; n < 5; n++) begin
      wr(CTB_OFF_TBL, 32'h1_FFF0);
      repeat (40) @(posedge SYS_CLK);
      #1;
      if (n < 3) `CHK("wd irq", 1'b1, WD_IRQ)
      if (n < 2) wr(CTB_OFF_CLEAR, 32'h4);
      if (n < 3) `CHK("wd early", 1'b0, WD_RESET)
    end
    `CHK("wd reset", 1'b1, WD_RESET)
    `CHK("wd kind", CTB_RST_CORE, WD_RESET_KIND)
    // Reset driven on the edge like the bus inputs
    @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    @(posedge SYS_CLK);
    #1;
    `CHK("wd cleared", 1'b0, WD_RESET)
    $display("test watchdog done");
    close_out;
  end
endmodule : tb_ctb_timers
`default_nettype wire
